/* File: design/pss_config_regs.sv */
`timescale 1ns/1ps
`include "pss_regs.svh"

module pss_config_regs
    import pss_pkg::*;
#(
    // bus address value is arbitrary
    parameter logic [6:0] DEV_ADDR = 7'h2a
)
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic converter_on_i,
    output pss_cfg_t cfg_o,
    output logic [4:0] fb_divide_ratio_o,
    output logic [11:0] cable_drop_comp_gain_mv_o,
    output logic aux_driver_active_o,
    output logic aux_driver_open_drain_o,
    output logic current_limit_dac_disable_o,
    output logic [9:0] window_low_tenths_o,
    output logic [13:0] ovp_thresh_mv_o,
    output logic ovp_thresh_valid_o
);

////////////////////////////////////////////////////////////////////////////
// pin synchronisers

    logic scl_s1_q;
    logic scl_s2_q;
    logic scl_s3_q;
    logic sda_s1_q;
    logic sda_s2_q;
    logic sda_s3_q;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= scl_i;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    wire scl_rise = scl_s2_q & ~scl_s3_q;
    wire scl_fall = ~scl_s2_q & scl_s3_q;
    wire scl_high = scl_s2_q & scl_s3_q;
    wire start_det = scl_high & sda_s3_q & ~sda_s2_q;
    wire stop_det = scl_high & ~sda_s3_q & sda_s2_q;

////////////////////////////////////////////////////////////////////////////
// serial register port

    pss_state_t st_q;
    pss_state_t st_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic rw_q;
    logic rw_d;
    logic nack_q;
    logic nack_d;
    logic oe_n_q;
    logic oe_n_d;
    logic sda_q;
    logic wr_en;
    logic [7:0] rdata;

    wire byte_in = cnt_q == 4'h8;
    wire addr_match = shift_q[7:1] == DEV_ADDR;
    wire [7:0] ptr_inc = ptr_q + 8'h01;

    always_comb begin
        st_d = st_q;
        shift_d = shift_q;
        cnt_d = cnt_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        nack_d = nack_q;
        oe_n_d = oe_n_q;
        wr_en = 1'b0;
        if (start_det) begin
            // repeated start keeps the pointer for a following read
            st_d = ST_ADDR;
            cnt_d = 4'h0;
            oe_n_d = 1'b1;
        end else if (stop_det) begin
            st_d = ST_IDLE;
            oe_n_d = 1'b1;
        end else begin
            case (st_q)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise && !byte_in) begin
                        shift_d = {shift_q[6:0], sda_s2_q};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && byte_in) begin
                        cnt_d = 4'h0;
                        oe_n_d = 1'b0;
                        if (st_q == ST_ADDR) begin
                            if (addr_match) begin
                                rw_d = shift_q[0];
                                st_d = ST_ADDR_ACK;
                            end else begin
                                // not our address: stay off the wire
                                oe_n_d = 1'b1;
                                st_d = ST_IDLE;
                            end
                        end else if (st_q == ST_PTR) begin
                            ptr_d = shift_q;
                            st_d = ST_PTR_ACK;
                        end else begin
                            wr_en = 1'b1; // RULE13
                            ptr_d = ptr_inc;
                            st_d = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            shift_d = rdata; // RULE13
                            ptr_d = ptr_inc;
                            oe_n_d = rdata[7];
                            st_d = ST_RDATA;
                        end else begin
                            oe_n_d = 1'b1;
                            st_d = ST_PTR;
                        end
                    end
                end
                ST_PTR_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_n_d = 1'b1;
                        st_d = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_q == 4'h7) begin
                            cnt_d = 4'h0;
                            oe_n_d = 1'b1;
                            st_d = ST_RDATA_ACK;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            oe_n_d = shift_q[6];
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        nack_d = sda_s2_q;
                    end else if (scl_fall) begin
                        if (nack_q) begin
                            st_d = ST_IDLE;
                        end else begin
                            shift_d = rdata;
                            ptr_d = ptr_inc;
                            oe_n_d = rdata[7];
                            st_d = ST_RDATA;
                        end
                    end
                end
                ST_IDLE: begin
                    oe_n_d = 1'b1;
                end
                default: begin
                    oe_n_d = 1'b1;
                    st_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= ST_IDLE;
            shift_q <= 8'h00;
            cnt_q <= 4'h0;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            nack_q <= 1'b1;
            oe_n_q <= 1'b1;
            sda_q <= 1'b0;
        end else begin
            st_q <= st_d;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            nack_q <= nack_d;
            oe_n_q <= oe_n_d;
            sda_q <= 1'b0;
        end
    end

    // open drain: only ever pulls low, a one is a released line
    assign sda_o = sda_q;
    assign sda_oe_n_o = oe_n_q;

////////////////////////////////////////////////////////////////////////////
// register bank

    pss_cfg_t cfg;

    pss_reg_bank u_bank (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(wr_en),
        .addr_i(ptr_q),
        .wdata_i(shift_q),
        .rdata_o(rdata),
        .cfg_o(cfg)
    );

    assign cfg_o = cfg;

////////////////////////////////////////////////////////////////////////////
// decoded configuration

    logic [4:0] fb_ratio_q;
    logic [11:0] cdc_mv_q;
    logic aux_act_q;
    logic aux_od_q;
    logic dac_dis_q;
    logic [9:0] win_q;
    logic [13:0] ovp_mv_q;
    logic ovp_ok_q;

    wire [4:0] fb_ratio_d = cfg.feedback_divider_select ?
                            `PSS_FB_DIV_HI : `PSS_FB_DIV_LO; // RULE4
    wire [11:0] cdc_mv_d = `PSS_CDC_BASE_MV <<
                           cfg.cable_drop_comp_gain; // RULE6

    // aux driver follows the converter only in the two tracking codes
    wire [1:0] seq = cfg.aux_driver_sequencing;
    wire aux_act_d = (seq == `PSS_SEQ_OFF_ACTIVE) ? ~converter_on_i :
                     (seq == `PSS_SEQ_ON_ACTIVE) ? converter_on_i :
                     (seq == `PSS_SEQ_FORCE_ON); // RULE7
    wire aux_od_d = cfg.aux_driver_supply_select ==
                    `PSS_SUP_OPEN_DRAIN; // RULE8

    // 0x14 breaks the 2.5% ladder, so it is caught by itself
    wire [4:0] win_code = cfg.window_low_code;
    wire [9:0] win_d = (win_code == `PSS_WIN_ODD_CODE) ?
                       `PSS_WIN_ODD_TENTHS :
                       10'(win_code) * `PSS_WIN_STEP; // RULE11

    // codes above the linear range are flagged and decoded from their low six bits only
    wire [7:0] ovp_code = cfg.input_ovp_threshold_code;
    wire ovp_ok_d = ovp_code <= `PSS_OVP_LIN_MAX;
    wire [13:0] ovp_mv_d = `PSS_OVP_BASE_MV +
                           14'(ovp_code[5:0]) * `PSS_OVP_STEP_MV; // RULE12

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fb_ratio_q <= `PSS_FB_DIV_HI;
            cdc_mv_q <= 12'h000;
            aux_act_q <= 1'b0;
            aux_od_q <= 1'b1;
            dac_dis_q <= 1'b1;
            win_q <= 10'h000;
            ovp_mv_q <= `PSS_OVP_BASE_MV;
            ovp_ok_q <= 1'b0;
        end else begin
            fb_ratio_q <= fb_ratio_d;
            cdc_mv_q <= cable_drop_gate(cdc_mv_d);
            aux_act_q <= aux_act_d;
            aux_od_q <= aux_od_d;
            dac_dis_q <= cfg.current_set_pin_force; // RULE10
            win_q <= win_d;
            ovp_mv_q <= ovp_mv_d;
            ovp_ok_q <= ovp_ok_d;
        end
    end

    // gain reads zero while compensation is switched off
    function automatic logic [11:0] cable_drop_gate(input logic [11:0] mv);
        cable_drop_gate = cfg.cable_drop_comp_enable ? mv : 12'h000; // RULE5
    endfunction

    assign fb_divide_ratio_o = fb_ratio_q;
    assign cable_drop_comp_gain_mv_o = cdc_mv_q;
    assign aux_driver_active_o = aux_act_q;
    assign aux_driver_open_drain_o = aux_od_q;
    assign current_limit_dac_disable_o = dac_dis_q;
    assign window_low_tenths_o = win_q;
    assign ovp_thresh_mv_o = ovp_mv_q;
    assign ovp_thresh_valid_o = ovp_ok_q;

endmodule

/* File: design/pss_regs.svh */
// Function
// RULE1 - The first configuration register sits at 0xd8 and reads 0x84 after reset.
// RULE2 - The second configuration register sits at 0xd9 and reads 0x2c after reset.
// RULE3 - The input overvoltage threshold register at 0xda is one 8-bit read/write field that resets to 0xff.
// RULE4 - Bit 7 of the first register picks feedback divide-by-ten (0) or divide-by-twenty (1), reset 1.
// RULE5 - Bit 6 of the first register enables cable drop compensation when 1, reset 0.
// RULE6 - Bits 5:4 of the first register pick compensation gain 0.250V, 0.500V, 1.000V or 2.000V, reset 0.
// RULE7 - Bits 3:2 of the first register set aux driver sequencing: active while off, while on, forced on, forced off; reset 1.
// RULE8 - Bits 1:0 of the first register pick aux driver supply: open drain, output, bias, charge pump; reset 0.
// RULE9 - Bits 7:6 of the second register always read zero and writes to them are dropped.
// RULE10 - Bit 5 of the second register, reset 1, forces the current-set pin to bus mode and disables the current-limit DAC.
// RULE11 - Bits 4:0 of the second register set the lower window in 2.50% steps, 0 disables, 0x14 means 50.5%, reset 0xc.
// RULE12 - The overvoltage code maps 0 to 4.75V plus 0.125V per code up to 0x3f and sets both protection and regulation threshold.
// RULE13 - Each register is accessed as a whole byte over the serial port and writes reach the outputs at once.
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

`define PSS_ADDR_FB_AUX 8'hd8
`define PSS_ADDR_PIN_WIN 8'hd9
`define PSS_ADDR_OVP 8'hda

`define PSS_RST_FB_AUX 8'h84
`define PSS_RST_PIN_WIN 8'h2c
`define PSS_RST_OVP 8'hff

`define PSS_PIN_WIN_WMASK 8'h3f

`define PSS_FB_DIV_LO 5'h0a
`define PSS_FB_DIV_HI 5'h14
`define PSS_CDC_BASE_MV 12'h0fa
`define PSS_WIN_STEP 10'h019
`define PSS_WIN_ODD_CODE 5'h14
`define PSS_WIN_ODD_TENTHS 10'h1f9
`define PSS_OVP_BASE_MV 14'h128e
`define PSS_OVP_STEP_MV 14'h007d
`define PSS_OVP_LIN_MAX 8'h3f

`define PSS_SEQ_OFF_ACTIVE 2'h0
`define PSS_SEQ_ON_ACTIVE 2'h1
`define PSS_SEQ_FORCE_ON 2'h2
`define PSS_SUP_OPEN_DRAIN 2'h0

`endif

/* File: design/pss_pkg.sv */
package pss_pkg;

    typedef struct packed {
        logic feedback_divider_select;
        logic cable_drop_comp_enable;
        logic [1:0] cable_drop_comp_gain;
        logic [1:0] aux_driver_sequencing;
        logic [1:0] aux_driver_supply_select;
        logic current_set_pin_force;
        logic [4:0] window_low_code;
        logic [7:0] input_ovp_threshold_code;
    } pss_cfg_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } pss_state_t;

endpackage

/* File: design/pss_reg_bank.sv */
`timescale 1ns/1ps
`include "pss_regs.svh"

module pss_reg_bank
    import pss_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output pss_cfg_t cfg_o
);

    logic [7:0] fb_aux_q;
    logic [7:0] pin_win_q;
    logic [7:0] ovp_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    wire sel_fb_aux = addr_i == `PSS_ADDR_FB_AUX;
    wire sel_pin_win = addr_i == `PSS_ADDR_PIN_WIN;
    wire sel_ovp = addr_i == `PSS_ADDR_OVP;

    // unmapped pointers read as zero
    assign rdata_d = sel_fb_aux ? fb_aux_q :
                     sel_pin_win ? (pin_win_q & `PSS_PIN_WIN_WMASK) :
                     sel_ovp ? ovp_q : 8'h00; // RULE9

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fb_aux_q <= `PSS_RST_FB_AUX; // RULE1
            pin_win_q <= `PSS_RST_PIN_WIN; // RULE2
            ovp_q <= `PSS_RST_OVP; // RULE3
            rdata_q <= 8'h00;
        end else begin
            if (wr_en_i && sel_fb_aux) begin
                fb_aux_q <= wdata_i; // RULE13
            end
            if (wr_en_i && sel_pin_win) begin
                pin_win_q <= wdata_i & `PSS_PIN_WIN_WMASK; // RULE9
            end
            if (wr_en_i && sel_ovp) begin
                ovp_q <= wdata_i; // RULE3
            end
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
    assign cfg_o.feedback_divider_select = fb_aux_q[7]; // RULE4
    assign cfg_o.cable_drop_comp_enable = fb_aux_q[6]; // RULE5
    assign cfg_o.cable_drop_comp_gain = fb_aux_q[5:4]; // RULE6
    assign cfg_o.aux_driver_sequencing = fb_aux_q[3:2]; // RULE7
    assign cfg_o.aux_driver_supply_select = fb_aux_q[1:0]; // RULE8
    assign cfg_o.current_set_pin_force = pin_win_q[5]; // RULE10
    assign cfg_o.window_low_code = pin_win_q[4:0]; // RULE11
    assign cfg_o.input_ovp_threshold_code = ovp_q; // RULE12

endmodule

/* File: bench/pss_config_regs_chk.sv */
`timescale 1ns/1ps
module pss_config_regs_chk
    import pss_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic sda_oe_n_o,
    input wire logic converter_on_i,
    input wire pss_cfg_t cfg_o,
    input wire logic [4:0] fb_divide_ratio_o,
    input wire logic [11:0] cable_drop_comp_gain_mv_o,
    input wire logic aux_driver_active_o,
    input wire logic aux_driver_open_drain_o,
    input wire logic current_limit_dac_disable_o,
    input wire logic [9:0] window_low_tenths_o,
    input wire logic [13:0] ovp_thresh_mv_o,
    input wire logic ovp_thresh_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    //////////////////////////////
    // decoded outputs show reset values, not decodes, right after reset
    sequence s_run;
        !$past(sys_rst_i);
    endsequence
    sequence s_low_held;
        !sda_oe_n_o [*3];
    endsequence
    //////////////////////////////
    a_fb_ratio: assert property (s_run |-> fb_divide_ratio_o ==
        ($past(cfg_o.feedback_divider_select) ? 5'h14 : 5'h0a))
        else $error("feedback ratio decode wrong");
    a_cable_drop_comp_gain: assert property (s_run |-> cable_drop_comp_gain_mv_o ==
        ($past(cfg_o.cable_drop_comp_enable) ?
        12'h0fa << $past(cfg_o.cable_drop_comp_gain) : 12'h000))
        else $error("compensation gain decode wrong");
    a_aux_seq: assert property (s_run |-> aux_driver_active_o == (
        ($past(cfg_o.aux_driver_sequencing) == 2'h0) ?
        !$past(converter_on_i) :
        ($past(cfg_o.aux_driver_sequencing) == 2'h1) ?
        $past(converter_on_i) : ($past(cfg_o.aux_driver_sequencing) == 2'h2)))
        else $error("aux driver sequencing wrong");
    a_open_drain: assert property (s_run |-> aux_driver_open_drain_o
        == ($past(cfg_o.aux_driver_supply_select) == 2'h0))
        else $error("aux supply decode wrong");
    a_dac_disable: assert property (s_run |->
        current_limit_dac_disable_o == $past(cfg_o.current_set_pin_force))
        else $error("current limit dac disable wrong");
    a_window_low: assert property (s_run |-> window_low_tenths_o ==
        (($past(cfg_o.window_low_code) == 5'h14) ? 10'h1f9 :
        10'($past(cfg_o.window_low_code)) * 10'h019))
        else $error("window threshold decode wrong");
    a_ovp_mv: assert property (s_run |-> ovp_thresh_mv_o ==
        14'h128e + 14'($past(cfg_o.input_ovp_threshold_code[5:0])) *
        14'h007d)
        else $error("overvoltage threshold decode wrong");
    a_ovp_valid: assert property (s_run |-> ovp_thresh_valid_o ==
        ($past(cfg_o.input_ovp_threshold_code) <= 8'h3f))
        else $error("overvoltage valid flag wrong");
    a_pull_held: assert property ($fell(sda_oe_n_o) |-> s_low_held)
        else $error("data line pull too short");
endmodule

bind pss_config_regs pss_config_regs_chk pss_config_regs_chk_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sda_oe_n_o(sda_oe_n_o),
    .converter_on_i(converter_on_i), .cfg_o(cfg_o),
    .fb_divide_ratio_o(fb_divide_ratio_o), .cable_drop_comp_gain_mv_o(cable_drop_comp_gain_mv_o),
    .aux_driver_active_o(aux_driver_active_o),
    .aux_driver_open_drain_o(aux_driver_open_drain_o),
    .current_limit_dac_disable_o(current_limit_dac_disable_o),
    .window_low_tenths_o(window_low_tenths_o),
    .ovp_thresh_mv_o(ovp_thresh_mv_o), .ovp_thresh_valid_o(ovp_thresh_valid_o)
);

/* File: bench/pss_host_model.sv */
`timescale 1ns/1ps
module pss_host_model (
    input wire logic clk_i,
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // both scl phases stay above the 8-cycle minimum
    task automatic hp();
        repeat (10) @(negedge clk_i);
    endtask
    // data moves a few cycles after scl falls, never with it
    task automatic pulse(output logic v);
        hp();
        scl_o = 1'b1;
        hp();
        v = sda_line_i;
        scl_o = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask
    task automatic start();
        sda_o = 1'b1;
        hp();
        scl_o = 1'b1;
        hp();
        sda_o = 1'b0;
        hp();
        scl_o = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask
    task automatic stop();
        sda_o = 1'b0;
        hp();
        scl_o = 1'b1;
        hp();
        sda_o = 1'b1;
        hp();
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            sda_o = b[i];
            pulse(v);
        end
        sda_o = 1'b1;
        pulse(v);
        ack = !v;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic v;
        sda_o = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            pulse(v);
            b[i] = v;
        end
        sda_o = last;
        pulse(v);
    endtask
endmodule

/* File: bench/tb_power_stage_config_regs.sv */
`timescale 1ns/1ps
`define CHK(a, b) \
    comparisons++; \
    if ((a) !== (b)) begin \
        n_fail++; \
        $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); \
    end
module tb_power_stage_config_regs
    import pss_pkg::*;
;
    localparam logic [6:0] DEV = 7'h2a;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic conv_on = 1'b0;
    logic scl, h_sda, sda_o, sda_oe_n, sda_line, nak;
    pss_cfg_t cfg;
    logic [4:0] fb;
    logic [11:0] cdc;
    logic aux, od, dac, valid;
    logic [9:0] win;
    logic [13:0] ovp;
    int n_fail = 0;
    int comparisons = 0;
    int mdl [3];
    logic [7:0] wbuf [3];

    always #20 clk = ~clk;
    // pull-up: line is low when either side pulls
    assign sda_line = h_sda & (sda_oe_n | sda_o);

    pss_config_regs #(.DEV_ADDR(DEV)) pss_config_regs_inst (
        .clk_i(clk), .sys_rst_i(sys_rst), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .converter_on_i(conv_on),
        .cfg_o(cfg), .fb_divide_ratio_o(fb), .cable_drop_comp_gain_mv_o(cdc),
        .aux_driver_active_o(aux), .aux_driver_open_drain_o(od),
        .current_limit_dac_disable_o(dac), .window_low_tenths_o(win),
        .ovp_thresh_mv_o(ovp), .ovp_thresh_valid_o(valid)
    );
    pss_host_model pss_host_model_inst (
        .clk_i(clk), .sda_line_i(sda_line), .scl_o(scl), .sda_o(h_sda)
    );
    //////////////////////////////
    task automatic mreset();
        mdl[0] = 32'h84;
        mdl[1] = 32'h2c;
        mdl[2] = 32'hff;
    endtask
    task automatic mput(input logic [7:0] a, input logic [7:0] v);
        if (a >= 8'hd8 && a <= 8'hda)
            mdl[a - 8'hd8] = (a == 8'hd9) ? v & 8'h3f : v;
    endtask
    // unmapped places read as zero
    function automatic logic [7:0] mget(input logic [7:0] a);
        return (a >= 8'hd8 && a <= 8'hda) ? 8'(mdl[a - 8'hd8]) : 8'h00;
    endfunction
    function automatic logic aux_exp(input logic [1:0] s, input logic on);
        return (s == 2'h0) ? !on : (s == 2'h1) ? on : (s == 2'h2);
    endfunction
    //////////////////////////////
    task automatic open(input logic [7:0] ptr);
        pss_host_model_inst.start();
        pss_host_model_inst.wbyte({DEV, 1'b0}, nak);
        `CHK(nak, 1'b1)
        pss_host_model_inst.wbyte(ptr, nak);
        `CHK(nak, 1'b1)
    endtask
    task automatic wr(input logic [7:0] ptr, input int n);
        open(ptr);
        for (int k = 0; k < n; k++) begin
            pss_host_model_inst.wbyte(wbuf[k], nak);
            `CHK(nak, 1'b1)
            mput(ptr + 8'(k), wbuf[k]);
        end
        pss_host_model_inst.stop();
    endtask
    task automatic rd(input logic [7:0] ptr, input int n);
        logic [7:0] b;
        open(ptr);
        pss_host_model_inst.start();
        pss_host_model_inst.wbyte({DEV, 1'b1}, nak);
        `CHK(nak, 1'b1)
        for (int k = 0; k < n; k++) begin
            pss_host_model_inst.rbyte(k == n - 1, b);
            `CHK(b, mget(ptr + 8'(k)))
        end
        pss_host_model_inst.stop();
    endtask
    task automatic check_all();
        logic [7:0] r0, r1, r2;
        r0 = mget(8'hd8);
        r1 = mget(8'hd9);
        r2 = mget(8'hda);
        for (int v = 0; v < 2; v++) begin
            conv_on = v[0];
            repeat (3) @(negedge clk);
            `CHK(aux, aux_exp(r0[3:2], v[0]))
        end
        `CHK(cfg, {r0, r1[5:0], r2})
        `CHK(fb, r0[7] ? 5'h14 : 5'h0a)
        `CHK(cdc, r0[6] ? 12'h0fa << r0[5:4] : 12'h000)
        `CHK(od, r0[1:0] == 2'h0)
        `CHK(dac, r1[5])
        `CHK(win, (r1[4:0] == 5'h14) ? 10'h1f9 :
            10'(r1[4:0]) * 10'h019)
        `CHK(valid, r2 <= 8'h3f)
        `CHK(ovp, 14'h128e + 14'(r2[5:0]) * 14'h007d)
    endtask
    task automatic conclude();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    //////////////////////////////
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        conclude();
    end
    initial begin
        void'($urandom(36774));
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        mreset();
        check_all();
        rd(8'hd8, 3);
        // every first-register field code met at least once, boundaries forced
        for (int i = 0; i < 6; i++) begin
            wbuf[0] = 8'($urandom);
            // divider and compensation enable both take each value
            wbuf[0][7:6] = 2'(i);
            wbuf[0][5:4] = 2'(i);
            wbuf[0][3:2] = 2'(i);
            wbuf[0][1:0] = 2'(i + 1);
            wbuf[1] = 8'($urandom) | 8'hc0;
            wbuf[1][4:0] = (i == 2) ? 5'h14 : (i == 3) ? 5'h00 : wbuf[1][4:0];
            wbuf[2] = (i == 4) ? 8'h3f : 8'($urandom_range(32'h3f));
            wbuf[2] = (i == 5) ? 8'h40 | 8'($urandom) : wbuf[2];
            wr(8'hd8, 3);
            check_all();
            rd(8'hd8, 3);
        end
        wbuf[0] = 8'h5a;
        wr(8'hdb, 1);
        rd(8'hd7, 5);
        pss_host_model_inst.start();
        pss_host_model_inst.wbyte({DEV ^ 7'h01, 1'b0}, nak);
        `CHK(nak, 1'b0)
        pss_host_model_inst.stop();
        check_all();
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        mreset();
        check_all();
        rd(8'hd8, 3);
        conclude();
    end
endmodule
